// File: logic/uart_status_consts.vh
// Constants for the UART status flag block
`ifndef UART_STATUS_CONSTS_VH
`define UART_STATUS_CONSTS_VH
// Register indices
`define REG_RXDATA 3'h0
`define REG_TXDATA 3'h1
`define REG_STATUS 3'h2
`define REG_CONTROL 3'h3
`define REG_EOPCHAR 3'h5
// Status and control bit positions
`define BIT_PARITY_ERR 0
`define BIT_STOP_ERR 1
`define BIT_BRK 2
`define BIT_ROE 3
`define BIT_TOE 4
`define BIT_TMT 5
`define BIT_TRDY 6
`define BIT_RRDY 7
`define BIT_E 8
`define BIT_RSVD 9
`define BIT_DCTS 10
`define BIT_CTS 11
`define BIT_EOP 12
// Character time in bit periods: start, 8 data, parity, stop
`define CHAR_BITS 4'hB
`define BIT_TICKS 16'h0010
`define FIFO_DEPTH 32
`define FIFO_AW 5
`define CTRL_RST 13'h0000
// Control bits that enable an interrupt; transmit-break and request-to-send do not
`define IRQ_ENABLES 13'h15FF
`endif

// File: logic/char_fifo.v
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module char_fifo #(
   parameter W = 8,
   parameter DEPTH = 32,
   parameter AW = 5
)(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // Drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem [0:DEPTH-1];
   reg [AW:0] wp_q;
   reg [AW:0] rp_q;
   wire empty = (wp_q == rp_q);
   wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   assign in_ready = ~full;
   assign out_valid = ~empty;
   assign out_data = mem[rp_q[AW-1:0]];
   always @(posedge mclk)
   begin
      if (in_valid && !full)
      begin
         mem[wp_q[AW-1:0]] <= in_data;
      end
   end
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         wp_q <= {(AW+1){1'b0}};
         rp_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (in_valid && !full)
            wp_q <= wp_q + 1'b1;
         if (out_ready && !empty)
            rp_q <= rp_q + 1'b1;
      end
   end
endmodule // char_fifo

// File: logic/uart_status_flags.v
// UART status flags with holding registers and register port
// Operation
// - Break when rx low past character time
// - Sticky flags hold until status write
// - Rx overrun when ready still set; overwrite
// - Tx overrun on write while not ready
// - Shift-empty bit low while shifting
// - Tx ready reflects holding register empty
// - Rx ready set on load, cleared by read
// - Exception is OR of error flags
// - Exception plus enable covers all errors
// - Clear-to-send change flag on either edge
// - Clear-to-send bit shows sampled level
// - Clear-to-send never affects data path
// - Without flow control, both bits zero
// - End-of-packet on matching tx write/rx read
// - Without end-of-packet option, flag zero
// - Status reads change nothing
// - Stop-bit error set on bad stop bit
// - Interrupt when flag and enable both set
`timescale 1ns/1ps
`include "uart_status_consts.vh"
module uart_status_flags #(
   parameter FLOW_CONTROL = 1,
   parameter HAS_EOP = 1,
   parameter HAS_PARITY = 1
)(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register port
   input wire [2:0] address,
   input wire chipselect,
   input wire read_n,
   input wire write_n,
   input wire [15:0] writedata,
   output reg [15:0] readdata,
   output wire irq,
   // Serial link
   input wire rxd,
   input wire cts_n,
   // Receiver event inputs
   input wire rx_char_valid,
   input wire [7:0] rx_char,
   input wire rx_stop_bad,
   input wire rx_parity_bad,
   // Transmit shifter side
   output wire tx_char_valid,
   input wire tx_char_ready,
   output wire [7:0] tx_char,
   input wire tx_shifting,
   // Write-queue back-pressure towards the bus master
   output wire tx_queue_ready
);
   // ********************************
   // Bus decode
   // ********************************
   wire wr = chipselect & ~write_n;
   wire rd = chipselect & ~read_n;
   wire wr_status = wr && (address == `REG_STATUS);
   wire wr_ctrl = wr && (address == `REG_CONTROL);
   wire wr_eop = wr && (address == `REG_EOPCHAR);
   wire wr_tx = wr && (address == `REG_TXDATA);
   wire rd_rx = rd && (address == `REG_RXDATA);

   reg [12:0] ctrl_q;
   reg [7:0] eop_char_q;
   reg [7:0] rx_hold_q;
   reg parity_error_flag_q, stop_bit_error_flag_q, brk_q, roe_q, toe_q, rrdy_q, dcts_q, eop_q, e_q;
   reg cts_s1_q, cts_s2_q, cts_prev_q;
   reg [15:0] tick_q;
   reg [3:0] low_bits_q;
   reg brk_seen_q;

   // ********************************
   // Transmit holding queue
   // ********************************
   // One-deep holding register semantics are kept by the ready flag;
   // the queue only soaks up shifter stalls.
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [7:0] fifo_out_data;
   reg hold_full_q;
   // Holding register empties once the last queued character moves to the shifter
   reg [5:0] fifo_cnt_q;
   wire fifo_out_valid_more = (fifo_cnt_q > 6'h01);
   wire trdy = ~hold_full_q;
   char_fifo #(.W(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) tx_queue (
      .mclk(mclk),
      .rst(rst),
      .in_valid(wr_tx),
      .in_ready(fifo_in_ready),
      .in_data(writedata[7:0]),
      .out_valid(fifo_out_valid),
      .out_ready(tx_char_ready),
      .out_data(fifo_out_data)
   );
   assign tx_char_valid = fifo_out_valid;
   assign tx_char = fifo_out_data;
   assign tx_queue_ready = fifo_in_ready;

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         hold_full_q <= 1'b0;
      else if (wr_tx)
         hold_full_q <= 1'b1;
      else if (tx_char_ready && fifo_out_valid && !fifo_out_valid_more)
         hold_full_q <= 1'b0;
   end
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         fifo_cnt_q <= 6'h00;
      else
         fifo_cnt_q <= fifo_cnt_q + {5'h00, wr_tx && fifo_in_ready}
            - {5'h00, tx_char_ready && fifo_out_valid};
   end

   // ********************************
   // Clear-to-send sampling
   // ********************************
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         cts_s1_q <= 1'b0;
         cts_s2_q <= 1'b0;
         cts_prev_q <= 1'b0;
      end
      else
      begin
         cts_s1_q <= ~cts_n;
         cts_s2_q <= cts_s1_q;
         cts_prev_q <= cts_s2_q;
      end
   end
   // Change compares settled samples only, never the first stage
   wire cts_edge = (cts_s2_q != cts_prev_q);

   // ********************************
   // Break detection
   // ********************************
   wire tick = (tick_q == `BIT_TICKS - 16'h0001);
   wire brk_now = tick && (low_bits_q == `CHAR_BITS) && !brk_seen_q;
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         tick_q <= 16'h0000;
         low_bits_q <= 4'h0;
         brk_seen_q <= 1'b0;
      end
      else if (rxd)
      begin
         tick_q <= 16'h0000;
         low_bits_q <= 4'h0;
         brk_seen_q <= 1'b0;
      end
      else
      begin
         tick_q <= tick ? 16'h0000 : tick_q + 16'h0001;
         if (tick && low_bits_q != `CHAR_BITS)
            low_bits_q <= low_bits_q + 4'h1;
         if (brk_now)
            brk_seen_q <= 1'b1;
      end
   end

   // ********************************
   // Flags
   // ********************************
   wire tx_ovr = wr_tx && !trdy;
   wire rx_eop = rd_rx && (rx_hold_q == eop_char_q);
   wire tx_eop = wr_tx && (writedata[7:0] == eop_char_q);
   always @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         {parity_error_flag_q, stop_bit_error_flag_q, brk_q, roe_q, toe_q} <= 5'h00;
         {rrdy_q, dcts_q, eop_q, e_q} <= 4'h0;
         rx_hold_q <= 8'h00;
         ctrl_q <= `CTRL_RST;
         eop_char_q <= 8'h00;
      end
      else
      begin
         if (wr_ctrl)
            ctrl_q <= writedata[12:0];
         if (wr_eop)
            eop_char_q <= writedata[7:0];
         // Sets win over the status-write clear; an rx-data read clears only rrdy_q here
         parity_error_flag_q <= (parity_error_flag_q & ~wr_status)
            | (rx_char_valid & rx_parity_bad & (HAS_PARITY != 0));
         stop_bit_error_flag_q <= (stop_bit_error_flag_q & ~wr_status)
            | (rx_char_valid & rx_stop_bad);
         brk_q <= (brk_q & ~wr_status) | brk_now;
         roe_q <= (roe_q & ~wr_status) | (rx_char_valid & rrdy_q);
         toe_q <= (toe_q & ~wr_status) | tx_ovr;
         dcts_q <= (dcts_q & ~wr_status) | (cts_edge & (FLOW_CONTROL != 0));
         eop_q <= (eop_q & ~wr_status) | ((rx_eop | tx_eop) & (HAS_EOP != 0));
         // Exception latches the OR of error sets and clears on status write
         e_q <= (e_q & ~wr_status) | (rx_char_valid & (rx_stop_bad | rrdy_q))
            | (rx_char_valid & rx_parity_bad & (HAS_PARITY != 0))
            | brk_now | tx_ovr;
         if (rx_char_valid)
            rx_hold_q <= rx_char;
         if (rx_char_valid)
            rrdy_q <= 1'b1;
         else if (rd_rx)
            rrdy_q <= 1'b0;
      end
   end

   // ********************************
   // Status image, read data and interrupt
   // ********************************
   wire cts_bit = (FLOW_CONTROL != 0) ? cts_s2_q : 1'b0;
   wire dcts_bit = (FLOW_CONTROL != 0) ? dcts_q : 1'b0;
   wire eop_bit = (HAS_EOP != 0) ? eop_q : 1'b0;
   wire e_bit = e_q | parity_error_flag_q | stop_bit_error_flag_q
      | brk_q | roe_q | toe_q;
   wire [12:0] status;
   assign status[`BIT_PARITY_ERR] = parity_error_flag_q;
   assign status[`BIT_STOP_ERR] = stop_bit_error_flag_q;
   assign status[`BIT_BRK] = brk_q;
   assign status[`BIT_ROE] = roe_q;
   assign status[`BIT_TOE] = toe_q;
   assign status[`BIT_TMT] = ~tx_shifting;
   assign status[`BIT_TRDY] = trdy;
   assign status[`BIT_RRDY] = rrdy_q;
   assign status[`BIT_E] = e_bit;
   assign status[`BIT_RSVD] = 1'b0;
   assign status[`BIT_DCTS] = dcts_bit;
   assign status[`BIT_CTS] = cts_bit;
   assign status[`BIT_EOP] = eop_bit;
   // Transmit-break and request-to-send are plain controls, so they never gate an interrupt
   wire [12:0] irq_mask = ctrl_q & `IRQ_ENABLES;
   assign irq = |(status & irq_mask);

   always @(posedge mclk or posedge rst)
   begin
      if (rst)
         readdata <= 16'h0000;
      else if (rd)
      begin
         case (address)
            `REG_RXDATA: readdata <= {8'h00, rx_hold_q};
            `REG_STATUS: readdata <= {3'h0, status};
            `REG_CONTROL: readdata <= {3'h0, ctrl_q};
            `REG_EOPCHAR: readdata <= {8'h00, eop_char_q};
            default: readdata <= 16'h0000;
         endcase
      end
   end
endmodule // uart_status_flags

// File: verification/shifter_model.sv
// Transmit shifter model with a settable character time
`timescale 1ns/1ps
module shifter_model(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Hand-off and shift state
   input wire tx_char_valid,
   output reg tx_char_ready,
   output reg tx_shifting,
   // Bench controls
   input wire [7:0] span,
   output reg [7:0] taken
);
   reg [7:0] cnt_q;
   // Ready stays low while busy, so the queue sees real back-pressure
   always @(posedge mclk or posedge rst)
      if (rst)
         {tx_char_ready, tx_shifting, cnt_q, taken} <= 18'h20000;
      else if (tx_char_valid && tx_char_ready)
      begin
         {tx_char_ready, tx_shifting, cnt_q} <= {2'h1, span};
         taken <= taken + 8'h01;
      end
      else if (cnt_q != 8'h00)
         cnt_q <= cnt_q - 8'h01;
      else
         {tx_char_ready, tx_shifting} <= 2'h2;
endmodule // shifter_model

// File: verification/uart_status_flags_assertions.sv
// Assertions for the UART status flags
`timescale 1ns/1ps
module uart_status_checks #(
   parameter FLOW = 1
)(
   // Clock and reset
   input wire mclk,
   input wire rst,
   // Register port
   input wire [2:0] address,
   input wire chipselect,
   input wire read_n,
   input wire write_n,
   input wire [15:0] readdata,
   // Line and event inputs
   input wire rxd,
   input wire cts_n,
   input wire rx_char_valid,
   input wire tx_shifting
);
   wire rs = chipselect && !read_n && write_n && address == 3'h2;
   wire ws = chipselect && !write_n && address == 3'h2;
   wire rr = chipselect && !read_n && address == 3'h0;
   wire wt = chipselect && !write_n && address == 3'h1;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence rx_twice;
      rx_char_valid && !rr ##1 !rr ##1 rx_char_valid;
   endsequence
   sequence tx_twice;
      wt ##1 wt;
   endsequence
   shift_idle_a: assert property (rs |=> readdata[5] == !$past(tx_shifting))
      else $error("shift idle bit wrong");
   cts_level_a: assert property (rs && $stable(cts_n) && $past(cts_n) == $past(cts_n, 2)
      |=> readdata[11] == (FLOW != 0 && !$past(cts_n))) else $error("cts level wrong");
   rx_set_a: assert property (rx_char_valid && !rr ##1 rs |=> readdata[7])
      else $error("rx ready not set");
   rx_clear_a: assert property (rr && !rx_char_valid ##1 rs |=> !readdata[7])
      else $error("rx ready not cleared");
   rx_overrun_a: assert property (rx_twice ##1 rs |=> readdata[3] && readdata[8])
      else $error("rx overrun missed");
   tx_overrun_a: assert property (tx_twice ##1 rs |=> readdata[4])
      else $error("tx overrun missed");
   sticky_hold_a: assert property (rs ##1 rs
      |=> (readdata[4:2] & $past(readdata[4:2])) == $past(readdata[4:2])) else $error("flag lost");
   sticky_clear_a: assert property (ws && rxd && $past(rxd) && !rx_char_valid ##1 rs && rxd
      |=> readdata[4:2] == 3'h0 && !readdata[8]) else $error("flags not cleared");
   cts_change_a: assert property ($changed(cts_n) ##1 !ws [*4] ##1 rs |=> readdata[10] == (FLOW != 0))
      else $error("cts change missed");
endmodule // uart_status_checks
bind uart_status_flags uart_status_checks #(.FLOW(FLOW_CONTROL)) uart_status_checks_i(.mclk, .rst, .address,
   .chipselect, .read_n, .write_n, .readdata, .rxd, .cts_n, .rx_char_valid, .tx_shifting);

// File: verification/uart_status_flags_tb_top.sv
// Self-checking bench for the UART status flags
`timescale 1ns/1ps
module uart_status_flags_tb_top;
   reg mclk, rst, chipselect, read_n, write_n, rxd, cts_n;
   reg rx_char_valid, rx_stop_bad, rx_parity_bad;
   reg [2:0] address;
   reg [15:0] writedata;
   reg [7:0] rx_char, span, c;
   reg [31:0] seed;
   wire [15:0] readdata;
   wire [15:0] readdata_lite;
   wire [7:0] taken;
   wire irq, tx_char_valid, tx_char_ready, tx_shifting, tx_queue_ready;
   integer fail_count, tests_run, i;
   uart_status_flags uart_status_flags_i(.mclk, .rst, .address, .chipselect, .read_n,
      .write_n, .writedata, .readdata, .irq, .rxd, .cts_n, .rx_char_valid, .rx_char,
      .rx_stop_bad, .rx_parity_bad, .tx_char_valid, .tx_char_ready, .tx_char(),
      .tx_shifting, .tx_queue_ready);
   // Variant without flow control, end-of-packet or parity options
   uart_status_flags #(.FLOW_CONTROL(0), .HAS_EOP(0), .HAS_PARITY(0)) uart_status_flags_lite_i(
      .mclk, .rst, .address, .chipselect, .read_n, .write_n, .writedata,
      .readdata(readdata_lite), .irq(), .rxd, .cts_n, .rx_char_valid, .rx_char,
      .rx_stop_bad, .rx_parity_bad, .tx_char_valid(), .tx_char_ready, .tx_char(),
      .tx_shifting, .tx_queue_ready());
   shifter_model shifter_model_i(.mclk, .rst, .tx_char_valid, .tx_char_ready,
      .tx_shifting, .span, .taken);
   initial
   begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // ***
   // Helpers
   // ***
   function [31:0] xs(input [31:0] s);
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
   endfunction
   // Idle shifter status plus exception from any error flag
   function [15:0] st(input [15:0] f);
      st = f | 16'h0060 | {7'h00, |f[4:0], 8'h00};
   endfunction
   task chk(input [15:0] seen, input [15:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp)
         begin
            fail_count = fail_count + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   // Strobes stay asserted so accesses can run back to back
   task acc(input w, input [2:0] a, input [15:0] d);
      begin
         {address, writedata, chipselect, write_n, read_n} = {a, d, 1'b1, !w, w};
         @(posedge mclk);
         #1;
      end
   endtask
   task rd(input [2:0] a, input [15:0] e);
      begin
         acc(1'b0, a, 16'h0000);
         chk(readdata, e);
      end
   endtask
   task idle(input integer n);
      begin
         chipselect = 1'b0;
         repeat (n) @(posedge mclk);
         #1;
      end
   endtask
   task rxp(input [7:0] ch, input bad);
      begin
         {rx_char, rx_stop_bad, rx_parity_bad, rx_char_valid} = {ch, bad, bad, 1'b1};
         @(posedge mclk);
         #1;
         rx_char_valid = 1'b0;
      end
   endtask
   task end_of_test;
      begin
         $display("Checks %0d, mismatches %0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0)
            $display("TEST PASSED");
         else
            $display("TEST FAILED");
         $finish;
      end
   endtask
   // ***
   // Scenarios
   // ***
   initial
   begin
      {chipselect, rx_char_valid, rx_stop_bad, rx_parity_bad, address} = 7'h00;
      {read_n, write_n, rxd, cts_n, rst} = 5'h1F;
      {writedata, rx_char, span, fail_count, tests_run} = {24'h000000, 8'h28, 64'h0};
      seed = 32'h3B276667;
      repeat (5) @(posedge mclk);
      #1;
      rst = 1'b0;
      rd(3'h2, 16'h0060);
      rd(3'h7, 16'h0000);
      for (i = 0; i < 4; i = i + 1)
      begin
         seed = xs(seed);
         c = seed[7:0] | 8'h01;
         idle(1);
         rxp(c, 1'b0);
         rd(3'h2, st(16'h0080));
         rd(3'h0, {8'h00, c});
         rd(3'h2, 16'h0060);
      end
      idle(1);
      rxp(8'h5A, 1'b0);
      idle(1);
      rxp(8'hA5, 1'b0);
      rd(3'h2, st(16'h0088));
      rd(3'h0, 16'h00A5);
      acc(1'b1, 3'h2, 16'h0000);
      rd(3'h2, 16'h0060);
      idle(1);
      rxp(8'h11, 1'b1);
      rd(3'h2, st(16'h0083));
      acc(1'b1, 3'h2, 16'h0000);
      acc(1'b0, 3'h0, 16'h0000);
      $display("test rx done");
      // Writes past a full queue on purpose, with the shifter stalled
      for (i = 0; i < 34; i = i + 1)
      begin
         seed = xs(seed);
         acc(1'b1, 3'h1, {8'h00, seed[7:0] | 8'h01});
      end
      rd(3'h2, 16'h0110);
      chk({15'h0000, tx_queue_ready}, 16'h0000);
      idle(1);
      for (i = 0; i < 3000 && (tx_char_valid || tx_shifting); i = i + 1)
         #40;
      chk({8'h00, taken}, 16'h0021);
      rd(3'h2, st(16'h0010));
      span = 8'h08;
      acc(1'b1, 3'h2, 16'h0000);
      acc(1'b1, 3'h5, 16'h0033);
      acc(1'b1, 3'h1, 16'h0033);
      idle(20);
      rd(3'h2, st(16'h1000));
      chk(readdata_lite, 16'h0060);
      acc(1'b1, 3'h2, 16'h0000);
      idle(1);
      rxp(8'h33, 1'b0);
      rd(3'h2, st(16'h0080));
      rd(3'h0, 16'h0033);
      rd(3'h2, st(16'h1000));
      acc(1'b1, 3'h2, 16'h0000);
      $display("test tx done");
      cts_n = 1'b0;
      idle(5);
      rd(3'h2, st(16'h0C00));
      chk(readdata_lite, 16'h0060);
      acc(1'b1, 3'h3, 16'h0400);
      chk({15'h0000, irq}, 16'h0001);
      acc(1'b1, 3'h2, 16'h0000);
      idle(1);
      chk({15'h0000, irq}, 16'h0000);
      cts_n = 1'b1;
      idle(5);
      rd(3'h2, st(16'h0400));
      acc(1'b1, 3'h3, 16'h0000);
      idle(1);
      chk({15'h0000, irq}, 16'h0000);
      acc(1'b1, 3'h2, 16'h0000);
      rxd = 1'b0;
      idle(170);
      rd(3'h2, 16'h0060);
      idle(21);
      rd(3'h2, st(16'h0004));
      rd(3'h2, st(16'h0004));
      rxd = 1'b1;
      acc(1'b1, 3'h3, 16'h0100);
      chk({15'h0000, irq}, 16'h0001);
      acc(1'b1, 3'h2, 16'h0000);
      idle(1);
      chk({15'h0000, irq}, 16'h0000);
      $display("test flags done");
      end_of_test;
   end
   // Run needs about 1700 cycles; allow far more before cutting it off
   initial
   begin
      #2000000;
      fail_count = fail_count + 1;
      end_of_test;
   end
endmodule // uart_status_flags_tb_top
